// ===== mbpwm_pkg.sv
/*
 * Shared constants of the match based PWM timer: sizes, register
 * offsets, field positions and reset values.
 * Assumes a single 250 MHz clock domain and a plain register port.
 */
package mbpwm_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int MBP_NM = 7;
  localparam int MBP_NO = 6;
  localparam int MBP_DW = 32;
  localparam int MBP_AW = 8;
  localparam int MBP_MCW = 3 * MBP_NM;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] MBP_OFF_ISTS = 8'h00;
  localparam logic [7:0] MBP_OFF_CTL = 8'h04;
  localparam logic [7:0] MBP_OFF_CNT = 8'h08;
  localparam logic [7:0] MBP_OFF_PLIM = 8'h0c;
  localparam logic [7:0] MBP_OFF_PCNT = 8'h10;
  localparam logic [7:0] MBP_OFF_MCTL = 8'h14;
  localparam logic [7:0] MBP_OFF_MATCH0 = 8'h18;
  localparam logic [7:0] MBP_OFF_REL = 8'h34;
  localparam logic [7:0] MBP_OFF_PCTL = 8'h38;
  localparam logic [7:0] MBP_OFF_IMSK = 8'h3c;
  localparam logic [7:0] MBP_OFF_OUT = 8'h40;
  localparam logic [7:0] MBP_MATCH_STEP = 8'h04;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MBP_CTL_CEN = 0;
  localparam int MBP_CTL_CRST = 1;
  localparam int MBP_CTL_PWM = 2;
  localparam int MBP_CTL_W = 3;
  localparam int MBP_MC_IRQ = 0;
  localparam int MBP_MC_RST = 1;
  localparam int MBP_MC_STP = 2;
  localparam int MBP_PCTL_DBL = 0;
  localparam int MBP_PCTL_OEN = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] MBP_RST32 = 32'h0;
  localparam logic [MBP_CTL_W-1:0] MBP_RST_CTL = 3'h0;
  localparam logic [MBP_MCW-1:0] MBP_RST_MCTL = 21'h0;
  localparam logic [MBP_NM-1:0] MBP_RST_NM = 7'h0;
  localparam logic [MBP_NO-1:0] MBP_RST_NO = 6'h0;

  // Picks one option bit of one match out of the match control word
  function automatic logic mbpwm_mbit(input logic [MBP_MCW-1:0] mc, input int idx,
                                      input int kind);
    mbpwm_mbit = mc[3 * idx + kind];
  endfunction

endpackage

// ===== mbpwm_prescale.sv
/*
 * Prescaler of the match based PWM timer: emits one tick each time the
 * prescale count reaches its programmed limit, then restarts from zero.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ns
module mbpwm_prescale
  import mbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic clr,
  input wire logic [MBP_DW-1:0] limit,
  output logic tick,
  output logic [MBP_DW-1:0] pcnt_r
);

  // ****************************************
  // Prescale counter
  // ****************************************
  // Limit of zero gives one tick per clock
  assign tick = run && !clr && (pcnt_r == limit);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pcnt_r <= MBP_RST32;
    end else if (clr || tick) begin
      pcnt_r <= MBP_RST32;
    end else if (run) begin
      pcnt_r <= pcnt_r + 32'h1;
    end
  end

endmodule

// ===== mbpwm_edge.sv
/*
 * One PWM output stage. Single edge: set at cycle start, cleared by its
 * own match. Double edge: set by the previous match, cleared by its own.
 * Assumes match events are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ns
module mbpwm_edge
  import mbpwm_pkg::*;
#(
  parameter int IDX = 1
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pwm_en,
  input wire logic oen,
  input wire logic dbl,
  input wire logic [MBP_NM-1:0] hit,
  output logic out_r
);

  logic set_ev;
  logic clr_ev;

  // Output one has no earlier partner, so it is single edge only
  assign set_ev = (dbl && IDX > 1) ? hit[IDX-1] : hit[0];
  assign clr_ev = hit[IDX];

  // ****************************************
  // Output flip-flop
  // ****************************************
  // Clear beats set, so a match equal to the period keeps it low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_r <= 1'b0;
    end else if (!pwm_en || !oen) begin
      out_r <= 1'b0;
    end else if (clr_ev) begin
      out_r <= 1'b0;
    end else if (set_ev) begin
      out_r <= 1'b1;
    end
  end

endmodule

// ===== mbpwm_top.sv
/*
 * Match based PWM timer: 32-bit prescaled counter, seven shadowed match
 * registers, six PWM outputs, match interrupts, stop and reset options.
 * Assumes a register master on the same clock that reads data one cycle
 * after the read strobe and never overlaps read and write strobes.
 */
`timescale 1ns/1ns
module mbpwm_top
  import mbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [MBP_AW-1:0] reg_addr,
  input wire logic [MBP_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [MBP_DW-1:0] reg_rdata,
  output logic irq,
  output logic [MBP_NO-1:0] pwm_out
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [MBP_CTL_W-1:0] ctl_r;
  logic [MBP_DW-1:0] cnt_r;
  logic [MBP_DW-1:0] plim_r;
  logic [MBP_DW-1:0] pcnt;
  logic [MBP_MCW-1:0] mctl_r;
  logic [MBP_DW-1:0] shd_r [MBP_NM];
  logic [MBP_DW-1:0] act_r [MBP_NM];
  logic [MBP_NM-1:0] rel_r;
  logic [MBP_NO-1:0] dbl_r;
  logic [MBP_NO-1:0] oen_r;
  logic [MBP_NM-1:0] ists_r;
  logic [MBP_NM-1:0] imsk_r;
  logic [MBP_DW-1:0] rdata_r;
  logic [MBP_DW-1:0] rdata_nxt;
  logic [MBP_NM-1:0] hit;
  logic [MBP_NM-1:0] irq_en;
  logic [MBP_NM-1:0] rst_en;
  logic [MBP_NM-1:0] stp_en;
  logic [MBP_NM-1:0] shd_wr;
  logic tick;
  logic pwm_en;
  logic cyc_start;
  logic any_rst;
  logic any_stp;

  assign pwm_en = ctl_r[MBP_CTL_PWM];

  // Decodes one register write
  function automatic logic wr_at(input logic wr, input logic [7:0] a,
                                 input logic [7:0] off);
    wr_at = wr && (a == off);
  endfunction

  // ****************************************
  // Prescaler
  // ****************************************
  mbpwm_prescale u_pre (
    .clk(clk),
    .nrst(nrst),
    .run(ctl_r[MBP_CTL_CEN]),
    .clr(ctl_r[MBP_CTL_CRST]),
    .limit(plim_r),
    .tick(tick),
    .pcnt_r(pcnt)
  );

  // ****************************************
  // Match compare and per-match logic
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < MBP_NM; gi++) begin : g_match
      // Compare only on a tick, so each match is a single pulse
      assign hit[gi] = tick && (cnt_r == act_r[gi]);
      assign irq_en[gi] = mbpwm_mbit(mctl_r, gi, MBP_MC_IRQ);
      assign rst_en[gi] = mbpwm_mbit(mctl_r, gi, MBP_MC_RST);
      assign stp_en[gi] = mbpwm_mbit(mctl_r, gi, MBP_MC_STP);
      assign shd_wr[gi] = wr_at(reg_wr, reg_addr,
                                8'(MBP_OFF_MATCH0 + MBP_MATCH_STEP * gi));

      always_ff @(posedge clk) begin
        if (!nrst) begin
          shd_r[gi] <= MBP_RST32;
        end else if (shd_wr[gi]) begin
          shd_r[gi] <= reg_wdata;
        end
      end

      // In PWM mode the active copy only moves at cycle start
      always_ff @(posedge clk) begin
        if (!nrst) begin
          act_r[gi] <= MBP_RST32;
        end else if (!pwm_en) begin
          act_r[gi] <= shd_r[gi];
        end else if (cyc_start && rel_r[gi]) begin
          act_r[gi] <= shd_r[gi];
        end
      end
    end
  endgenerate

  assign cyc_start = hit[0] && pwm_en;
  assign any_rst = |(hit & rst_en) || cyc_start;
  assign any_stp = |(hit & stp_en);

  // ****************************************
  // Release flags
  // ****************************************
  // A release written in the copy cycle stays pending for the next cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rel_r <= MBP_RST_NM;
    end else if (wr_at(reg_wr, reg_addr, MBP_OFF_REL)) begin
      rel_r <= (rel_r & ~(cyc_start ? rel_r : MBP_RST_NM)) | reg_wdata[MBP_NM-1:0];
    end else if (cyc_start) begin
      rel_r <= MBP_RST_NM;
    end
  end

  // ****************************************
  // Timer counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= MBP_RST32;
    end else if (ctl_r[MBP_CTL_CRST]) begin
      cnt_r <= MBP_RST32;
    end else if (wr_at(reg_wr, reg_addr, MBP_OFF_CNT)) begin
      cnt_r <= reg_wdata;
    end else if (tick && any_rst) begin
      cnt_r <= MBP_RST32;
    end else if (tick) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // A stop match wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_r <= MBP_RST_CTL;
    end else begin
      if (wr_at(reg_wr, reg_addr, MBP_OFF_CTL)) begin
        ctl_r <= reg_wdata[MBP_CTL_W-1:0];
      end
      if (any_stp) begin
        ctl_r[MBP_CTL_CEN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      plim_r <= MBP_RST32;
    end else if (wr_at(reg_wr, reg_addr, MBP_OFF_PLIM)) begin
      plim_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mctl_r <= MBP_RST_MCTL;
    end else if (wr_at(reg_wr, reg_addr, MBP_OFF_MCTL)) begin
      mctl_r <= reg_wdata[MBP_MCW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dbl_r <= MBP_RST_NO;
      oen_r <= MBP_RST_NO;
    end else if (wr_at(reg_wr, reg_addr, MBP_OFF_PCTL)) begin
      dbl_r <= reg_wdata[MBP_PCTL_DBL +: MBP_NO];
      oen_r <= reg_wdata[MBP_PCTL_OEN +: MBP_NO];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ists_r <= MBP_RST_NM;
    end else begin
      ists_r <= (ists_r & ~(wr_at(reg_wr, reg_addr, MBP_OFF_ISTS) ?
                 reg_wdata[MBP_NM-1:0] : MBP_RST_NM)) | (hit & irq_en);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      imsk_r <= MBP_RST_NM;
    end else if (wr_at(reg_wr, reg_addr, MBP_OFF_IMSK)) begin
      imsk_r <= reg_wdata[MBP_NM-1:0];
    end
  end

  assign irq = |(ists_r & imsk_r);

  // ****************************************
  // Outputs
  // ****************************************
  generate
    for (gi = 0; gi < MBP_NO; gi++) begin : g_out
      mbpwm_edge #(.IDX(gi + 1)) u_edge (
        .clk(clk),
        .nrst(nrst),
        .pwm_en(pwm_en),
        .oen(oen_r[gi]),
        .dbl(dbl_r[gi]),
        .hit(hit),
        .out_r(pwm_out[gi])
      );
    end
  endgenerate

  // ****************************************
  // Register read
  // ****************************************
  always_comb begin
    rdata_nxt = MBP_RST32;
    unique case (reg_addr)
      MBP_OFF_ISTS: rdata_nxt[MBP_NM-1:0] = ists_r;
      MBP_OFF_CTL: rdata_nxt[MBP_CTL_W-1:0] = ctl_r;
      MBP_OFF_CNT: rdata_nxt = cnt_r;
      MBP_OFF_PLIM: rdata_nxt = plim_r;
      MBP_OFF_PCNT: rdata_nxt = pcnt;
      MBP_OFF_MCTL: rdata_nxt[MBP_MCW-1:0] = mctl_r;
      MBP_OFF_REL: rdata_nxt[MBP_NM-1:0] = rel_r;
      MBP_OFF_PCTL: begin
        rdata_nxt[MBP_PCTL_DBL +: MBP_NO] = dbl_r;
        rdata_nxt[MBP_PCTL_OEN +: MBP_NO] = oen_r;
      end
      MBP_OFF_IMSK: rdata_nxt[MBP_NM-1:0] = imsk_r;
      MBP_OFF_OUT: rdata_nxt[MBP_NO-1:0] = pwm_out;
      default: begin
        for (int i = 0; i < MBP_NM; i++) begin
          if (reg_addr == 8'(MBP_OFF_MATCH0 + MBP_MATCH_STEP * i)) begin
            rdata_nxt = shd_r[i];
          end
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= MBP_RST32;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : MBP_RST32;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_stop;
    any_stp && !ctl_r[MBP_CTL_CRST];
  endsequence

  sequence s_frozen;
    !ctl_r[MBP_CTL_CEN] ##1 !tick;
  endsequence

  cnt_advance_a: assert property (tick && !any_rst && !ctl_r[MBP_CTL_CRST] &&
    !reg_wr |=> cnt_r == $past(cnt_r) + 32'h1) else $error("counter did not advance");
  pre_tick_a: assert property (tick |=> pcnt == MBP_RST32)
    else $error("prescaler did not restart");
  period_reset_a: assert property (cyc_start && !reg_wr |=> cnt_r == MBP_RST32)
    else $error("match zero did not reset count");
  single_rise_a: assert property (cyc_start && oen_r[0] && !hit[1] &&
    !reg_wr |=> pwm_out[0]) else $error("single output not set at cycle start");
  single_fall_a: assert property (hit[1] && !dbl_r[0] |=> !pwm_out[0])
    else $error("single output not cleared");
  dbl_rise_a: assert property (pwm_en && dbl_r[1] && oen_r[1] && hit[1] && !hit[2] &&
    !reg_wr |=> pwm_out[1]) else $error("double output not set");
  dbl_fall_a: assert property (hit[2] |=> !pwm_out[1])
    else $error("double output not cleared");
  irq_stick_a: assert property (|(hit & irq_en) |=> |ists_r)
    else $error("match interrupt lost");
  stop_freeze_a: assert property (s_stop |=> s_frozen)
    else $error("stop match did not halt counter");
  shadow_hold_a: assert property (pwm_en && !cyc_start ##1 pwm_en |->
    act_r[0] == $past(act_r[0])) else $error("active match changed mid cycle");
  release_copy_a: assert property (cyc_start && rel_r[0] |=>
    act_r[0] == $past(shd_r[0])) else $error("released value not copied");
  timer_mode_a: assert property (!pwm_en ##1 !pwm_en |-> pwm_out == MBP_RST_NO)
    else $error("outputs active without PWM mode");

endmodule

// ===== mbpwm_load.sv
/*
 * Load model for the six PWM outputs: measures each output's period and
 * high time between consecutive rising edges.
 * Assumes the outputs change only on rising clk edges.
 */
`timescale 1ns/1ns
module mbpwm_load
  import mbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [MBP_NO-1:0] pwm,
  output logic [15:0] per [MBP_NO],
  output logic [15:0] hi [MBP_NO]
);
  // ****************************************
  // Edge to edge measurement
  // ****************************************
  // A motor load sees only levels; no feedback is driven back
  logic [MBP_NO-1:0] prev_r;
  logic [15:0] cp_r [MBP_NO];
  logic [15:0] ch_r [MBP_NO];
  always_ff @(posedge clk) begin
    prev_r <= nrst ? pwm : '0;
    for (int k = 0; k < MBP_NO; k++) begin
      if (!nrst) begin
        cp_r[k] <= 16'h0;
        ch_r[k] <= 16'h0;
        per[k] <= 16'h0;
        hi[k] <= 16'h0;
      end else if (pwm[k] && !prev_r[k]) begin
        per[k] <= cp_r[k];
        hi[k] <= ch_r[k];
        cp_r[k] <= 16'h1;
        ch_r[k] <= 16'h1;
      end else begin
        cp_r[k] <= cp_r[k] + 16'h1;
        ch_r[k] <= ch_r[k] + {15'h0, pwm[k]};
      end
    end
  end
endmodule

// ===== test_mbpwm_top.sv
/*
 * Self-checking bench of the match based PWM timer.
 * Assumes the design files and mbpwm_load are compiled before it.
 */
`timescale 1ns/1ns
module test_mbpwm_top;
  import mbpwm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [MBP_AW-1:0] reg_addr = 8'h0;
  logic [MBP_DW-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [MBP_DW-1:0] reg_rdata;
  logic irq;
  logic [MBP_NO-1:0] pwm_out;
  logic [15:0] per [MBP_NO];
  logic [15:0] hi [MBP_NO];
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] d;

  always #2 clk = ~clk;

  mbpwm_top u_mbpwm_top (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .pwm_out(pwm_out));
  mbpwm_load u_mbpwm_load (.clk(clk), .nrst(nrst), .pwm(pwm_out), .per(per), .hi(hi));

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd(MBP_OFF_CTL);
    chk("ctl", 32'h0, d);
    rd(MBP_OFF_ISTS);
    chk("ists", 32'h0, d);
    rd(8'hfc);
    chk("unmapped", 32'h0, d);
    chk("pwm_out", 32'h0, {26'h0, pwm_out});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask

  // Values written with PWM off load the active set directly
  task automatic t_single;
    wr(MBP_OFF_MATCH0, 32'h7);
    wr(MBP_OFF_MATCH0 + MBP_MATCH_STEP, 32'h3);
    wr(MBP_OFF_PCTL, 32'h100);
    wr(MBP_OFF_CTL, 32'h5);
    wait_clk(40);
    chk("period0", 32'h8, {16'h0, per[0]});
    chk("high0", 32'h4, {16'h0, hi[0]});
    $display("test single edge done");
  endtask

  task automatic t_shadow;
    wr(MBP_OFF_MATCH0 + MBP_MATCH_STEP, 32'h5);
    wr(MBP_OFF_MATCH0, 32'h9);
    wait_clk(40);
    chk("high0 held", 32'h4, {16'h0, hi[0]});
    chk("period0 held", 32'h8, {16'h0, per[0]});
    wr(MBP_OFF_REL, 32'h3);
    wait_clk(40);
    chk("high0 new", 32'h6, {16'h0, hi[0]});
    chk("period0 new", 32'ha, {16'h0, per[0]});
    rd(MBP_OFF_REL);
    chk("rel cleared", 32'h0, d);
    $display("test shadow done");
  endtask

  task automatic t_double;
    wr(MBP_OFF_MATCH0 + MBP_MATCH_STEP, 32'h2);
    wr(MBP_OFF_MATCH0 + 8'h2 * MBP_MATCH_STEP, 32'h5);
    wr(MBP_OFF_REL, 32'h6);
    wr(MBP_OFF_PCTL, 32'h302);
    wait_clk(40);
    chk("pos high1", 32'h3, {16'h0, hi[1]});
    chk("pos period1", 32'ha, {16'h0, per[1]});
    wr(MBP_OFF_MATCH0 + MBP_MATCH_STEP, 32'h5);
    wr(MBP_OFF_MATCH0 + 8'h2 * MBP_MATCH_STEP, 32'h2);
    wr(MBP_OFF_REL, 32'h6);
    wait_clk(40);
    chk("neg high1", 32'h7, {16'h0, hi[1]});
    chk("high0 single", 32'h6, {16'h0, hi[0]});
    $display("test double edge done");
  endtask

  task automatic t_timer;
    wr(MBP_OFF_CTL, 32'h0);
    wr(MBP_OFF_CNT, 32'h0);
    wr(MBP_OFF_MATCH0 + 8'h3 * MBP_MATCH_STEP, 32'h14);
    wr(MBP_OFF_MCTL, 32'ha00);
    wr(MBP_OFF_IMSK, 32'h8);
    wr(MBP_OFF_CTL, 32'h1);
    wait_clk(40);
    chk("pwm off", 32'h0, {26'h0, pwm_out});
    rd(MBP_OFF_CTL);
    chk("stopped", 32'h0, d);
    rd(MBP_OFF_CNT);
    chk("cnt at stop", 32'h15, d);
    rd(MBP_OFF_ISTS);
    chk("ists3", 32'h8, d & 32'h8);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(MBP_OFF_IMSK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MBP_OFF_IMSK, 32'h8);
    wr(MBP_OFF_ISTS, 32'h8);
    wait_clk(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(MBP_OFF_MATCH0 + 8'h2 * MBP_MATCH_STEP, 32'h4);
    wr(MBP_OFF_MCTL, 32'h80);
    wr(MBP_OFF_CNT, 32'h0);
    wr(MBP_OFF_CTL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      rd(MBP_OFF_CNT);
      chk("cnt wraps", 32'h1, {31'h0, d <= 32'h4});
    end
    $display("test timer done");
  endtask

  task automatic t_prescale;
    wr(MBP_OFF_CTL, 32'h0);
    wr(MBP_OFF_MCTL, 32'h0);
    wr(MBP_OFF_PLIM, 32'h3);
    wr(MBP_OFF_MATCH0, 32'h3);
    wr(MBP_OFF_MATCH0 + MBP_MATCH_STEP, 32'h1);
    wr(MBP_OFF_PCTL, 32'h100);
    wr(MBP_OFF_CNT, 32'h0);
    wr(MBP_OFF_CTL, 32'h5);
    wait_clk(80);
    chk("pre period0", 32'h10, {16'h0, per[0]});
    chk("pre high0", 32'h8, {16'h0, hi[0]});
    rd(MBP_OFF_PCNT);
    chk("pcnt range", 32'h1, {31'h0, d <= 32'h3});
    $display("test prescale done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    wait_clk(1);
    t_reset();
    t_single();
    t_shadow();
    t_double();
    t_timer();
    t_prescale();
    complete_run();
  end

  // Tests take about 420 cycles; this allows over thirty times that
  initial begin
    #60000;
    n_errors++;
    complete_run();
  end
endmodule
